// *** sdcbs_core.sv ***
// command decoder and per-bank state tracker
`timescale 1ns/1ns
module sdcbs_core
  import sdcbs_pkg::*;
#(
  parameter int NB = 4,
  parameter int ROW_W = 14,
  parameter int MRD = SDCBS_MRD_CYC,
  parameter int RP = SDCBS_RP_CYC,
  parameter int RCD = SDCBS_RCD_CYC,
  parameter int RFC = SDCBS_RFC_CYC,
  parameter int WRC = SDCBS_WR_CYC,
  parameter int XSR = SDCBS_XSR_CYC,
  parameter int XP = SDCBS_XP_CYC,
  parameter int BCYC = SDCBS_BURST_CYC
) (
  input wire logic clk, // command clock
  input wire logic resetn, // asynchronous reset, active low
  input wire sdcbs_pkg::sdcbs_bus_type bus_in, // command pins
  input wire sdcbs_pkg::sdcbs_wdata_type wdata_in, // write data and masks
  input wire logic wdata_valid, // write data present
  output logic wdata_ready, // write data accepted
  output logic [15:0] store_data, // word to the array
  output logic [1:0] store_byte_en, // bytes written, mask low
  output logic store_valid, // array write strobe
  input wire logic store_ready, // array accepts store
  output logic [3:0] cmd_code_q, // last decoded command
  output logic [NB*7-1:0] bank_state_q, // one-hot state per bank
  output logic [5:0] dev_state_q, // one-hot device mode
  output logic [ROW_W-1:0] refresh_row_q, // internal refresh row
  output logic illegal_q // illegal command seen
);
  import sdcbs_pkg::*;

  logic [1:0] rst_sync_q;
  logic rst_n;
  sdcbs_bus_type s1_q;
  sdcbs_bus_type s2_q;
  logic cg_prev_q;
  sdcbs_cmd_type cmd;
  sdcbs_bank_type st_q [NB];
  logic [7:0] bcnt_q [NB];
  logic [7:0] acnt_q [NB];
  logic ap_q [NB];
  logic [7:0] dcnt_q;
  sdcbs_dev_type dev_q;
  logic [1:0] last_rd_bank_q;
  logic last_rd_live_q;
  logic bad;
  logic all_idle;
  logic [15:0] bd;
  logic [1:0] bm;
  logic bv;

  // cut an int count to counter width
  function automatic logic [7:0] cyc(input int n);
    cyc = (n < 1) ? 8'h01 : n[7:0];
  endfunction : cyc

  // reset release through two flip-flops
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  // pins pass two flip-flops before decode
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_q <= '1;
      s2_q <= '1;
      cg_prev_q <= 1'b0;
    end else begin
      s1_q <= bus_in;
      s2_q <= s1_q;
      cg_prev_q <= s2_q.clock_gate;
    end
  end

  // command decode
  always_comb begin
    cmd = SDCBS_C_NONE;
    if (!s2_q.chip_select_n) begin
      case ({s2_q.row_strobe_n, s2_q.col_strobe_n,
             s2_q.write_strobe_n})
        SDCBS_ENC_ACT: cmd = SDCBS_C_ACT;
        SDCBS_ENC_RD: cmd = SDCBS_C_RD;
        SDCBS_ENC_WR: cmd = SDCBS_C_WR;
        SDCBS_ENC_PRE: cmd = SDCBS_C_PRE;
        SDCBS_ENC_BST: cmd = s2_q.clock_gate ? SDCBS_C_BST
                                             : SDCBS_C_DSLP;
        SDCBS_ENC_REF: cmd = s2_q.clock_gate ? SDCBS_C_REF
                                             : SDCBS_C_SREF;
        SDCBS_ENC_MRS: cmd = SDCBS_C_MRS;
        default: cmd = SDCBS_C_NONE;
      endcase
    end
    // rules apply only with gate high on two edges in normal mode;
    // a falling gate lets only self refresh or deep sleep entry pass
    if (dev_q != SDCBS_D_NORMAL || !cg_prev_q) begin
      cmd = SDCBS_C_NONE;
    end else if (!s2_q.clock_gate && cmd != SDCBS_C_SREF &&
                 cmd != SDCBS_C_DSLP) begin
      cmd = SDCBS_C_NONE;
    end
  end

  // all banks idle check and legality of the command
  always_comb begin
    all_idle = 1'b1;
    for (int i = 0; i < NB; i++) begin
      if (st_q[i] != SDCBS_B_IDLE) all_idle = 1'b0;
    end
    bad = 1'b0;
    case (cmd)
      SDCBS_C_ACT: bad = st_q[s2_q.bank_select] != SDCBS_B_IDLE;
      SDCBS_C_RD, SDCBS_C_WR: begin
        bad = !(st_q[s2_q.bank_select] == SDCBS_B_ACTIVE ||
                ((st_q[s2_q.bank_select] == SDCBS_B_READING ||
                  st_q[s2_q.bank_select] == SDCBS_B_WRITING) &&
                 !ap_q[s2_q.bank_select]));
      end
      SDCBS_C_REF, SDCBS_C_MRS, SDCBS_C_SREF,
      SDCBS_C_DSLP: bad = !all_idle;
      default: bad = 1'b0;
    endcase
  end

  // per-bank state machines
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < NB; i++) begin
        st_q[i] <= SDCBS_B_IDLE;
        bcnt_q[i] <= SDCBS_CNT_RST;
        acnt_q[i] <= SDCBS_CNT_RST;
        ap_q[i] <= 1'b0;
      end
    end else begin
      for (int i = 0; i < NB; i++) begin
        logic hit;
        hit = s2_q.bank_select == i[1:0];
        if (bcnt_q[i] != 8'h00) bcnt_q[i] <= bcnt_q[i] - 8'h01;
        case (st_q[i])
          SDCBS_B_ACTIVATING: if (bcnt_q[i] <= 8'h01) begin
            st_q[i] <= SDCBS_B_ACTIVE;
          end
          SDCBS_B_PRECHARGING: if (bcnt_q[i] <= 8'h01) begin
            st_q[i] <= SDCBS_B_IDLE;
          end
          SDCBS_B_REFRESHING: if (bcnt_q[i] <= 8'h01) begin
            st_q[i] <= SDCBS_B_IDLE;
          end
          SDCBS_B_READING, SDCBS_B_WRITING: begin
            if (acnt_q[i] != 8'h00) acnt_q[i] <= acnt_q[i] - 8'h01;
            if (acnt_q[i] <= 8'h01) begin
              if (ap_q[i]) begin
                st_q[i] <= SDCBS_B_PRECHARGING;
                bcnt_q[i] <= cyc(RP);
              end else begin
                st_q[i] <= SDCBS_B_ACTIVE;
              end
            end
          end
          default: ;
        endcase
        if (!bad) begin
          case (cmd)
            SDCBS_C_ACT: if (hit) begin
              st_q[i] <= SDCBS_B_ACTIVATING;
              bcnt_q[i] <= cyc(RCD);
            end
            SDCBS_C_RD, SDCBS_C_WR: if (hit) begin
              st_q[i] <= (cmd == SDCBS_C_RD) ? SDCBS_B_READING
                                             : SDCBS_B_WRITING;
              ap_q[i] <= s2_q.precharge_flag_bit;
              acnt_q[i] <= (cmd == SDCBS_C_RD) ? cyc(BCYC)
                                               : cyc(BCYC + WRC);
            end
            SDCBS_C_PRE: begin
              if ((s2_q.precharge_flag_bit || hit) &&
                  st_q[i] != SDCBS_B_IDLE) begin
                st_q[i] <= SDCBS_B_PRECHARGING;
                bcnt_q[i] <= cyc(RP);
              end
            end
            SDCBS_C_BST: begin
              if (last_rd_live_q && last_rd_bank_q == i[1:0] &&
                  st_q[i] == SDCBS_B_READING && !ap_q[i]) begin
                st_q[i] <= SDCBS_B_ACTIVE;
              end
            end
            SDCBS_C_REF: begin
              st_q[i] <= SDCBS_B_REFRESHING;
              bcnt_q[i] <= cyc(RFC);
            end
            SDCBS_C_MRS: begin
              st_q[i] <= SDCBS_B_REFRESHING;
              bcnt_q[i] <= cyc(MRD);
            end
            default: ;
          endcase
        end
      end
    end
  end

  // track most recent plain read for burst terminate
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      last_rd_bank_q <= 2'h0;
      last_rd_live_q <= 1'b0;
    end else if (!bad && cmd == SDCBS_C_RD) begin
      last_rd_bank_q <= s2_q.bank_select;
      last_rd_live_q <= !s2_q.precharge_flag_bit;
    end else if (!bad && (cmd == SDCBS_C_BST || cmd == SDCBS_C_WR)) begin
      last_rd_live_q <= 1'b0;
    end
  end

  // device-wide mode: self refresh, deep sleep, power-down, exits
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dev_q <= SDCBS_D_NORMAL;
      dcnt_q <= SDCBS_CNT_RST;
    end else begin
      case (dev_q)
        SDCBS_D_NORMAL: begin
          if (!bad && cmd == SDCBS_C_SREF) begin
            dev_q <= SDCBS_D_SELF_REF;
          end else if (!bad && cmd == SDCBS_C_DSLP) begin
            dev_q <= SDCBS_D_SLEEP;
          end else if (cg_prev_q && !s2_q.clock_gate) begin
            dev_q <= SDCBS_D_PD;
          end
        end
        SDCBS_D_SELF_REF: if (s2_q.clock_gate) begin
          dev_q <= SDCBS_D_EXIT;
          dcnt_q <= cyc(XSR);
        end
        SDCBS_D_PD: if (s2_q.clock_gate) begin
          dev_q <= SDCBS_D_EXIT;
          dcnt_q <= cyc(XP);
        end
        SDCBS_D_SLEEP: if (s2_q.clock_gate) begin
          dev_q <= SDCBS_D_EXIT; // full init is the controller's task
          dcnt_q <= cyc(XP);
        end
        SDCBS_D_EXIT: begin
          dcnt_q <= dcnt_q - 8'h01;
          if (dcnt_q <= 8'h01) dev_q <= SDCBS_D_NORMAL;
        end
        default: dev_q <= SDCBS_D_NORMAL;
      endcase
    end
  end

  // internal refresh row counter, address inputs ignored
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      refresh_row_q <= '0;
    end else if (!bad && (cmd == SDCBS_C_REF ||
                          dev_q == SDCBS_D_SELF_REF)) begin
      refresh_row_q <= refresh_row_q + 1'b1;
    end
  end

  // write data buffer, masked bytes never enabled
  sdcbs_buf2 #(.W(18)) u_buf (
    .clk(clk),
    .rst_n(rst_n),
    .in_data(wdata_in),
    .in_valid(wdata_valid),
    .in_ready(wdata_ready),
    .out_data({bd, bm}),
    .out_valid(bv),
    .out_ready(store_ready || !store_valid)
  );

  // array store register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      store_data <= 16'h0000;
      store_byte_en <= 2'h0;
      store_valid <= 1'b0;
    end else if (store_ready || !store_valid) begin
      store_valid <= bv;
      store_data <= bd;
      store_byte_en <= ~bm;
    end
  end

  // status outputs
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cmd_code_q <= 4'h0;
      for (int i = 0; i < NB; i++) begin
        bank_state_q[i*7 +: 7] <= SDCBS_B_IDLE;
      end
      dev_state_q <= 6'h01;
      illegal_q <= 1'b0;
    end else begin
      cmd_code_q <= cmd;
      for (int i = 0; i < NB; i++) begin
        bank_state_q[i*7 +: 7] <= st_q[i];
      end
      dev_state_q <= dev_q;
      illegal_q <= bad && cmd != SDCBS_C_NONE;
    end
  end
endmodule : sdcbs_core

// *** sdcbs_pkg.sv ***
// package: command codes, bank states, timing counts and carrier structs
package sdcbs_pkg;
  // command strobe encodings (row, column, write strobe), active low
  localparam logic [2:0] SDCBS_ENC_ACT = 3'h3;
  localparam logic [2:0] SDCBS_ENC_RD = 3'h5;
  localparam logic [2:0] SDCBS_ENC_WR = 3'h4;
  localparam logic [2:0] SDCBS_ENC_PRE = 3'h2;
  localparam logic [2:0] SDCBS_ENC_BST = 3'h6;
  localparam logic [2:0] SDCBS_ENC_REF = 3'h1;
  localparam logic [2:0] SDCBS_ENC_MRS = 3'h0;
  localparam logic [2:0] SDCBS_ENC_NOP = 3'h7;
  // timing delays as nanoseconds, converted to cycles at 125 MHz
  localparam int SDCBS_CLK_PS = 8000;
  localparam int SDCBS_T_MODE_LOAD_NS = 16;
  localparam int SDCBS_T_PRECHARGE_NS = 24;
  localparam int SDCBS_T_ACT_ACCESS_NS = 24;
  localparam int SDCBS_T_REFRESH_NS = 144;
  localparam int SDCBS_T_WRITE_REC_NS = 16;
  localparam int SDCBS_T_SR_EXIT_NS = 200;
  localparam int SDCBS_T_PD_EXIT_NS = 8;
  localparam int SDCBS_BURST_LEN = 4;
  localparam int SDCBS_MRD_CYC = (SDCBS_T_MODE_LOAD_NS * 1000
    + SDCBS_CLK_PS - 1) / SDCBS_CLK_PS;
  localparam int SDCBS_RP_CYC = (SDCBS_T_PRECHARGE_NS * 1000
    + SDCBS_CLK_PS - 1) / SDCBS_CLK_PS;
  localparam int SDCBS_RCD_CYC = (SDCBS_T_ACT_ACCESS_NS * 1000
    + SDCBS_CLK_PS - 1) / SDCBS_CLK_PS;
  localparam int SDCBS_RFC_CYC = (SDCBS_T_REFRESH_NS * 1000
    + SDCBS_CLK_PS - 1) / SDCBS_CLK_PS;
  localparam int SDCBS_WR_CYC = (SDCBS_T_WRITE_REC_NS * 1000
    + SDCBS_CLK_PS - 1) / SDCBS_CLK_PS;
  localparam int SDCBS_XSR_CYC = (SDCBS_T_SR_EXIT_NS * 1000
    + SDCBS_CLK_PS - 1) / SDCBS_CLK_PS;
  localparam int SDCBS_XP_CYC = (SDCBS_T_PD_EXIT_NS * 1000
    + SDCBS_CLK_PS - 1) / SDCBS_CLK_PS;
  localparam int SDCBS_BURST_CYC = SDCBS_BURST_LEN / 2;
  localparam logic [7:0] SDCBS_CNT_RST = 8'h00;

  // decoded command kinds
  typedef enum logic [3:0] {
    SDCBS_C_NONE = 4'h0,
    SDCBS_C_ACT = 4'h1,
    SDCBS_C_RD = 4'h2,
    SDCBS_C_WR = 4'h3,
    SDCBS_C_PRE = 4'h4,
    SDCBS_C_BST = 4'h5,
    SDCBS_C_REF = 4'h6,
    SDCBS_C_MRS = 4'h7,
    SDCBS_C_SREF = 4'h8,
    SDCBS_C_DSLP = 4'h9
  } sdcbs_cmd_type;

  // per-bank state, one-hot
  typedef enum logic [6:0] {
    SDCBS_B_IDLE = 7'h01,
    SDCBS_B_ACTIVATING = 7'h02,
    SDCBS_B_ACTIVE = 7'h04,
    SDCBS_B_READING = 7'h08,
    SDCBS_B_WRITING = 7'h10,
    SDCBS_B_PRECHARGING = 7'h20,
    SDCBS_B_REFRESHING = 7'h40
  } sdcbs_bank_type;

  // device-wide mode, one-hot
  typedef enum logic [5:0] {
    SDCBS_D_NORMAL = 6'h01,
    SDCBS_D_BUSY = 6'h02,
    SDCBS_D_SELF_REF = 6'h04,
    SDCBS_D_SLEEP = 6'h08,
    SDCBS_D_PD = 6'h10,
    SDCBS_D_EXIT = 6'h20
  } sdcbs_dev_type;

  // sampled command bus
  typedef struct packed {
    logic chip_select_n;
    logic row_strobe_n;
    logic col_strobe_n;
    logic write_strobe_n;
    logic clock_gate;
    logic [1:0] bank_select;
    logic precharge_flag_bit;
  } sdcbs_bus_type;

  // write data word with its byte masks
  typedef struct packed {
    logic [15:0] data;
    logic [1:0] byte_mask;
  } sdcbs_wdata_type;
endpackage : sdcbs_pkg

// *** sdcbs_buf2.sv ***
// two-entry valid/ready buffer for write data
`timescale 1ns/1ns
module sdcbs_buf2 #(
  parameter int W = 18
) (
  input wire logic clk, // clock
  input wire logic rst_n, // synchronised reset, active low
  input wire logic [W-1:0] in_data, // incoming word
  input wire logic in_valid, // incoming word present
  output logic in_ready, // room for a word
  output logic [W-1:0] out_data, // oldest word
  output logic out_valid, // oldest word present
  input wire logic out_ready // drain accepts
);
  logic [W-1:0] mem_q [2];
  logic rd_q;
  logic wr_q;
  logic [1:0] cnt_q;
  logic [1:0] cnt_d;
  logic push;
  logic pop;

  // handshakes on both sides
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign cnt_d = cnt_q + {1'b0, push} - {1'b0, pop};
  assign out_valid = cnt_q != 2'h0;
  assign out_data = mem_q[rd_q];

  // storage and pointers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_q <= 1'b0;
      wr_q <= 1'b0;
      cnt_q <= 2'h0;
      in_ready <= 1'b1;
      mem_q[0] <= '0;
      mem_q[1] <= '0;
    end else begin
      if (push) begin
        mem_q[wr_q] <= in_data;
        wr_q <= ~wr_q;
      end
      if (pop) begin
        rd_q <= ~rd_q;
      end
      cnt_q <= cnt_d;
      in_ready <= cnt_d != 2'h2; // room flag kept in a flop
    end
  end
endmodule : sdcbs_buf2

// *** sdcbs_core_assertions.sv ***
// checker: timing relations of the command decoder and bank states
`timescale 1ns/1ns
module sdcbs_core_chk
  import sdcbs_pkg::*;
#(
  parameter int NB = 4,
  parameter int ROW_W = 14,
  parameter int RCD = 3
) (
  input wire logic clk, // clock
  input wire logic resetn, // reset, active low
  input wire sdcbs_pkg::sdcbs_bus_type bus_in, // command pins
  input wire logic [15:0] store_data, // array word
  input wire logic store_valid, // array strobe
  input wire logic store_ready, // array accepts
  input wire logic [3:0] cmd_code_q, // decoded command
  input wire logic [NB*7-1:0] bank_state_q, // bank states
  input wire logic [5:0] dev_state_q, // device mode
  input wire logic [ROW_W-1:0] refresh_row_q // refresh row
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  logic [7:0] act_len_q;
  // counts cycles bank 0 has spent activating
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn)
      act_len_q <= 8'h00;
    else if (bank_state_q[1])
      act_len_q <= act_len_q + 8'h01;
    else
      act_len_q <= 8'h00;
  end
  cs_high_a: assert property (bus_in.chip_select_n [*5]
    |-> cmd_code_q == SDCBS_C_NONE) else $error("command while deselected");
  nop_quiet_a: assert property ((!bus_in.chip_select_n &&
    {bus_in.row_strobe_n, bus_in.col_strobe_n, bus_in.write_strobe_n}
    == SDCBS_ENC_NOP) [*5] |-> cmd_code_q == SDCBS_C_NONE)
    else $error("no-operation decoded as a command");
  store_hold_a: assert property (store_valid && !store_ready
    |=> store_valid && $stable(store_data)) else $error("store lost");
  idle_entry_a: assert property ($rose(bank_state_q[0])
    |-> $past(bank_state_q[5] || bank_state_q[6]))
    else $error("bank idle without precharge");
  active_entry_a: assert property ($rose(bank_state_q[2])
    |-> $past(bank_state_q[1] || bank_state_q[3] || bank_state_q[4]))
    else $error("bank active without activation");
  act_len_a: assert property ($fell(bank_state_q[1])
    |-> act_len_q == RCD && bank_state_q[2])
    else $error("activate delay wrong");
  row_step_a: assert property ($changed(refresh_row_q)
    && !dev_state_q[2] && !dev_state_q[5]
    |-> cmd_code_q inside {SDCBS_C_REF, SDCBS_C_SREF}
    || $past(cmd_code_q) inside {SDCBS_C_REF, SDCBS_C_SREF})
    else $error("refresh row moved without refresh");
  sleep_hold_a: assert property ((!bus_in.clock_gate) [*3]
    ##0 dev_state_q[3] |=> dev_state_q[3]) else $error("sleep left");
  sref_hold_a: assert property ((!bus_in.clock_gate) [*3]
    ##0 dev_state_q[2] |=> dev_state_q[2]) else $error("self refresh left");
endmodule : sdcbs_core_chk

bind sdcbs_core sdcbs_core_chk #(.NB(NB), .ROW_W(ROW_W), .RCD(RCD))
  i_chk (.clk(clk), .resetn(resetn), .bus_in(bus_in),
  .store_data(store_data), .store_valid(store_valid),
  .store_ready(store_ready), .cmd_code_q(cmd_code_q),
  .bank_state_q(bank_state_q), .dev_state_q(dev_state_q),
  .refresh_row_q(refresh_row_q));

// *** sdcbs_ctlr_model.sv ***
// controller-side model: drives command pins and write data
`timescale 1ns/1ns
module sdcbs_ctlr_model
  import sdcbs_pkg::*;
(
  input wire logic clk, // clock
  output sdcbs_pkg::sdcbs_bus_type bus_in, // command pins
  output sdcbs_pkg::sdcbs_wdata_type wdata_in, // write word
  output logic wdata_valid, // word present
  input wire logic wdata_ready // word taken
);
  // idle bus at time zero
  initial begin
    bus_in = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 2'h0, 1'b0};
    wdata_in = '0;
    wdata_valid = 1'b0;
  end
  // one command for one edge, then no-operation with the same gate
  task automatic issue(input logic cs_n, input logic [2:0] enc,
    input logic gate, input logic [1:0] bank, input logic ap);
    @(posedge clk);
    bus_in <= '{cs_n, enc[2], enc[1], enc[0], gate, bank, ap};
    @(posedge clk);
    bus_in <= '{1'b0, 1'b1, 1'b1, 1'b1, gate, 2'h0, 1'b0};
  endtask : issue
  // one write word held until taken, then the lines show its inverse
  task automatic push(input logic [15:0] d, input logic [1:0] m);
    @(posedge clk);
    wdata_in <= '{d, m};
    wdata_valid <= 1'b1;
    do @(posedge clk); while (wdata_ready !== 1'b1);
    wdata_valid <= 1'b0;
    wdata_in <= ~{d, m};
  endtask : push
endmodule : sdcbs_ctlr_model

// *** sdcbs_core_tb.sv ***
// testbench: command decode and bank state scenarios
`timescale 1ns/1ns
module sdcbs_core_tb;
  import sdcbs_pkg::*;
  localparam int RCD = 3;
  logic clk;
  logic resetn;
  sdcbs_bus_type bus_in;
  sdcbs_wdata_type wdata_in;
  logic wdata_valid, wdata_ready, store_valid, store_ready, illegal_q;
  logic stall;
  logic [15:0] store_data;
  logic [1:0] store_byte_en;
  logic [3:0] cmd_code_q;
  logic [27:0] bank_state_q;
  logic [5:0] dev_state_q;
  logic [13:0] refresh_row_q;
  logic [17:0] st_q[$];
  int n_fail = 0;
  int compares = 0;
  int cyc = 0;
  sdcbs_ctlr_model i_ctl (.clk(clk), .bus_in(bus_in), .wdata_in(wdata_in),
    .wdata_valid(wdata_valid), .wdata_ready(wdata_ready));
  sdcbs_core #(.RP(3), .RCD(RCD), .RFC(4), .XSR(4), .XP(2),
    .BCYC(4)) i_dut (.clk(clk), .resetn(resetn),
    .bus_in(bus_in), .wdata_in(wdata_in), .wdata_valid(wdata_valid),
    .wdata_ready(wdata_ready), .store_data(store_data),
    .store_byte_en(store_byte_en), .store_valid(store_valid),
    .store_ready(store_ready), .cmd_code_q(cmd_code_q),
    .bank_state_q(bank_state_q), .dev_state_q(dev_state_q),
    .refresh_row_q(refresh_row_q), .illegal_q(illegal_q));
  // clock
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // array side: stalls every other cycle when asked, logs stores
  always @(posedge clk) begin
    store_ready <= stall ? ~store_ready : 1'b1;
    if (store_valid === 1'b1 && store_ready === 1'b1)
      st_q.push_back({store_data, store_byte_en});
  end
  // hang guard
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      print_verdict();
    end
  end
  function automatic logic [27:0] peek(input int k);
    if (k < 4)
      return 28'(bank_state_q[k*7 +: 7]);
    if (k == 4)
      return 28'(dev_state_q);
    if (k == 5)
      return 28'(cmd_code_q);
    return 28'(illegal_q);
  endfunction : peek
  task automatic chk(input logic [27:0] g, input logic [27:0] e);
    compares++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] %0t: got %0h wanted %0h", $time, g, e);
    end
  endtask : chk
  // polls a watched output until it shows v, at most lim cycles
  task automatic expect_k(input int k, input logic [27:0] v, input int lim);
    for (int i = 0; i < lim; i++) begin
      @(posedge clk);
      #1;
      if (peek(k) === v)
        break;
    end
    chk(peek(k), v);
  endtask : expect_k
  task automatic open_b(input logic [1:0] b);
    i_ctl.issue(1'b0, SDCBS_ENC_ACT, 1'b1, b, 1'b0);
    expect_k(b, SDCBS_B_ACTIVE, 10);
  endtask : open_b
  task automatic t_decode();
    logic [13:0] r;
    i_ctl.issue(1'b0, SDCBS_ENC_ACT, 1'b1, 2'h0, 1'b0);
    expect_k(5, SDCBS_C_ACT, 6);
    expect_k(0, SDCBS_B_ACTIVE, 10);
    i_ctl.issue(1'b0, SDCBS_ENC_RD, 1'b1, 2'h0, 1'b0);
    expect_k(5, SDCBS_C_RD, 6);
    expect_k(0, SDCBS_B_READING, 3);
    i_ctl.issue(1'b0, SDCBS_ENC_WR, 1'b1, 2'h0, 1'b0);
    expect_k(5, SDCBS_C_WR, 6);
    expect_k(0, SDCBS_B_WRITING, 3);
    i_ctl.issue(1'b0, SDCBS_ENC_RD, 1'b1, 2'h0, 1'b0);
    i_ctl.issue(1'b0, SDCBS_ENC_BST, 1'b1, 2'h0, 1'b0);
    expect_k(0, SDCBS_B_READING, 2);
    expect_k(5, SDCBS_C_BST, 6);
    expect_k(0, SDCBS_B_ACTIVE, 1);
    i_ctl.issue(1'b0, SDCBS_ENC_PRE, 1'b1, 2'h0, 1'b0);
    expect_k(5, SDCBS_C_PRE, 6);
    expect_k(0, SDCBS_B_IDLE, 10);
    i_ctl.issue(1'b0, SDCBS_ENC_MRS, 1'b1, 2'h0, 1'b0);
    expect_k(5, SDCBS_C_MRS, 6);
    expect_k(0, SDCBS_B_IDLE, 10);
    r = refresh_row_q;
    i_ctl.issue(1'b0, SDCBS_ENC_REF, 1'b1, 2'h2, 1'b1);
    expect_k(5, SDCBS_C_REF, 6);
    expect_k(0, SDCBS_B_IDLE, 12);
    chk(28'(refresh_row_q), 28'(r + 14'h0001));
  endtask : t_decode
  task automatic t_deselect();
    i_ctl.issue(1'b1, SDCBS_ENC_ACT, 1'b1, 2'h2, 1'b0);
    repeat (8) @(posedge clk);
    chk(peek(2), SDCBS_B_IDLE);
    i_ctl.issue(1'b0, SDCBS_ENC_RD, 1'b1, 2'h2, 1'b0);
    expect_k(6, 28'h1, 6);
    chk(peek(2), SDCBS_B_IDLE);
  endtask : t_deselect
  task automatic t_autopre();
    open_b(2'h0);
    i_ctl.issue(1'b0, SDCBS_ENC_RD, 1'b1, 2'h0, 1'b1);
    expect_k(0, SDCBS_B_IDLE, 15);
    open_b(2'h0);
    @(posedge clk) stall <= 1'b1;
    i_ctl.issue(1'b0, SDCBS_ENC_WR, 1'b1, 2'h0, 1'b1);
    i_ctl.push(16'hA5C3, 2'h1);
    i_ctl.push(16'h5A3C, 2'h2);
    i_ctl.push(16'h0FF0, 2'h0);
    i_ctl.push(16'hF00F, 2'h1);
    expect_k(0, SDCBS_B_IDLE, 40);
    repeat (10) @(posedge clk);
    stall <= 1'b0;
    chk(28'(st_q.size()), 28'h4);
    chk(st_q[0], {16'hA5C3, 2'h2});
    chk(st_q[1], {16'h5A3C, 2'h1});
    chk(st_q[2], {16'h0FF0, 2'h3});
    chk(st_q[3], {16'hF00F, 2'h2});
  endtask : t_autopre
  task automatic t_other();
    i_ctl.issue(1'b0, SDCBS_ENC_ACT, 1'b1, 2'h0, 1'b0);
    i_ctl.issue(1'b0, SDCBS_ENC_ACT, 1'b1, 2'h3, 1'b0);
    expect_k(0, SDCBS_B_ACTIVE, 10);
    expect_k(3, SDCBS_B_ACTIVE, 10);
    i_ctl.issue(1'b0, SDCBS_ENC_PRE, 1'b1, 2'h1, 1'b1);
    expect_k(0, SDCBS_B_IDLE, 10);
    chk(peek(3), SDCBS_B_IDLE);
  endtask : t_other
  task automatic t_power();
    i_ctl.issue(1'b0, SDCBS_ENC_REF, 1'b0, 2'h0, 1'b0);
    expect_k(4, SDCBS_D_SELF_REF, 6);
    i_ctl.issue(1'b0, SDCBS_ENC_ACT, 1'b0, 2'h1, 1'b0);
    repeat (6) @(posedge clk);
    chk(peek(4), SDCBS_D_SELF_REF);
    chk(peek(1), SDCBS_B_IDLE);
    i_ctl.issue(1'b0, SDCBS_ENC_NOP, 1'b1, 2'h0, 1'b0);
    expect_k(4, SDCBS_D_NORMAL, 20);
    i_ctl.issue(1'b0, SDCBS_ENC_REF, 1'b1, 2'h0, 1'b0);
    expect_k(0, SDCBS_B_REFRESHING, 6);
    expect_k(0, SDCBS_B_IDLE, 12);
    i_ctl.issue(1'b0, SDCBS_ENC_BST, 1'b0, 2'h0, 1'b0);
    expect_k(4, SDCBS_D_SLEEP, 6);
    repeat (6) @(posedge clk);
    chk(peek(4), SDCBS_D_SLEEP);
    i_ctl.issue(1'b0, SDCBS_ENC_NOP, 1'b1, 2'h0, 1'b0);
    expect_k(4, SDCBS_D_NORMAL, 20);
    open_b(2'h1);
    i_ctl.issue(1'b0, SDCBS_ENC_ACT, 1'b0, 2'h2, 1'b0);
    expect_k(4, SDCBS_D_PD, 6);
    chk(peek(2), SDCBS_B_IDLE);
    i_ctl.issue(1'b0, SDCBS_ENC_NOP, 1'b1, 2'h0, 1'b0);
    expect_k(4, SDCBS_D_NORMAL, 20);
  endtask : t_power
  task automatic print_verdict();
    $display("compares %0d failures %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : print_verdict
  // reset, then the scenarios in turn
  initial begin
    resetn = 1'b0;
    stall = 1'b0;
    store_ready = 1'b1;
    repeat (6) @(posedge clk);
    resetn <= 1'b1;
    repeat (4) @(posedge clk);
    t_decode();
    t_deselect();
    t_autopre();
    t_other();
    t_power();
    print_verdict();
  end
endmodule : sdcbs_core_tb
